//--- design/uepd_top.sv
// Endpoint data path, halt handling and transceiver control for one general endpoint.
//
// Contract
// - ISO IN serves one released packet per IN request.
// - Clear IN ready when slot frees.
// - ISO IN with nothing ready: empty packet, underrun.
// - Deferred packets wait for next frame start.
// - Deferred mode: early IN gets empty packet.
// - OUT supports bulk/interrupt and ISO modes.
// - OUT event on ready set or stall.
// - Bulk OUT received: set ready, raise event.
// - Show byte count of ready OUT packet.
// - Send stall held: stall every bulk/interrupt OUT.
// - Stall sent: event and sticky flag.
// - Second buffered packet re-sets ready at once.
// - ISO OUT: store, set ready, event.
// - ISO OUT without room: event, overrun.
// - ISO CRC error: store, ready, data error.
// - Speed picks pull-up line and speed.
// - Read-only line and receiver status bits.
`timescale 1ns/10ps
`default_nettype none
module uepd_top
	import uepd_pkg::*;
#(
	parameter int DEPTH = uepd_pkg::FIFO_DEPTH
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [3:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic sof_tok,
	input wire logic in_tok,
	input wire logic out_tok,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_end,
	input wire logic rx_crc_err,
	output logic rx_ready,
	output logic tx_data_pkt,
	output logic tx_zlp,
	output logic tx_nak,
	output logic tx_ack,
	output logic tx_stall,
	output logic in_event,
	output logic out_event,
	input wire logic vbus,
	input wire logic dp_i,
	input wire logic dn_i,
	output logic dp_o,
	output logic dn_o,
	output logic dp_oe,
	output logic dn_oe,
	output logic pullup_dp,
	output logic pullup_dn,
	output logic phy_on
);
	import uepd_pkg::*;

	// Writable transceiver fields: pull-up, enable, speed, test mode.
	logic pullup_en;
	logic phy_en;
	logic speed_full;
	uepd_test_t test_mode;
	// Deferred-send mode for isochronous IN.
	logic sof_deferred_send;
	// IN endpoint state.
	logic in_iso;
	logic in_dbl;
	logic in_underrun_flag;
	logic [1:0] in_slots;
	logic [1:0] in_rel;
	logic [1:0] next_in_slots;
	logic [1:0] next_in_rel;
	logic in_packet_ready;
	// OUT endpoint state.
	logic out_iso;
	logic out_dbl;
	logic send_stall;
	logic stall_sent_flag;
	logic out_overrun_flag;
	logic data_error_flag;
	logic out_packet_ready;
	logic [1:0] out_pkts;
	logic rx_active;
	logic [CNT_W-1:0] rx_cnt;
	logic [CNT_W-1:0] len_mem [2];
	logic len_wr_sel;
	logic len_rd_sel;
	// Line input synchronisers: vbus, D+, D- in that order.
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic [2:0] sync3;
	logic [2:0] line_now;
	// Decoded register strobes.
	logic wr_xc;
	logic wr_in_lo;
	logic wr_out_lo;
	logic fw_load_in;
	logic fw_clear_out;
	logic in_send;
	logic commit;
	logic [1:0] out_cap;
	logic [CNT_W-1:0] out_count;

	uepd_fifo_if #(.WIDTH(FIFO_WIDTH)) fq ();

	uepd_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(DEPTH)) u_fifo (
		.ref_clk(ref_clk),
		.srst(srst),
		.port(fq.user)
	);

	assign wr_xc = reg_wr && reg_addr == XCVR_CTRL_IDX;
	assign wr_in_lo = reg_wr && reg_addr == IN_CSR_LO_IDX;
	assign wr_out_lo = reg_wr && reg_addr == OUT_CSR_LO_IDX;
	assign fw_load_in = wr_in_lo && reg_wdata[IN_RDY] && in_slots != (in_dbl ? 2'd2 : 2'd1);
	assign fw_clear_out = wr_out_lo && !reg_wdata[OUT_RDY] && out_packet_ready;
	assign out_cap = out_dbl ? 2'd2 : 2'd1;
	assign commit = rx_active && rx_end;
	assign out_count = out_packet_ready ? len_mem[len_rd_sel] : '0;
	// Ready reads 1 only while every slot holds a packet.
	assign in_packet_ready = in_slots == (in_dbl ? 2'd2 : 2'd1);
	// A packet leaves on an IN token when one is released for sending.
	assign in_send = in_tok && in_rel != 2'd0;
	assign rx_ready = fq.in_ready;
	assign fq.in_valid = rx_active && rx_valid;
	assign fq.in_data = rx_data;
	assign fq.out_ready = reg_rd && reg_addr == FIFO_IDX;

	// Three-stage synchronisers; each bit updates only when stages two and three agree.
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_sync
			always_ff @(posedge ref_clk)
			begin
				if (srst)
				begin
					sync1[gi] <= 1'b0;
					sync2[gi] <= 1'b0;
					sync3[gi] <= 1'b0;
					line_now[gi] <= 1'b0;
				end
				else
				begin
					sync1[gi] <= gi == 0 ? vbus : (gi == 1 ? dp_i : dn_i);
					sync2[gi] <= sync1[gi];
					sync3[gi] <= sync2[gi];
					if (sync2[gi] == sync3[gi])
					begin
						line_now[gi] <= sync3[gi];
					end
				end
			end
		end
	endgenerate

	// Transceiver control fields, all zero after reset.
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			{pullup_en, phy_en, speed_full} <= XC_RESET[4:2];
			test_mode <= UEPD_TEST_NORMAL;
		end
		else if (wr_xc)
		begin
			pullup_en <= reg_wdata[XC_PULLUP];
			phy_en <= reg_wdata[XC_PHY_EN];
			speed_full <= reg_wdata[XC_SPEED];
			test_mode <= uepd_test_t'(reg_wdata[XC_TEST_HI:XC_TEST_LO]);
		end
	end

	// Pull-up placement and transceiver enable, registered onto the pins.
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			pullup_dp <= 1'b0;
			pullup_dn <= 1'b0;
			phy_on <= 1'b0;
		end
		else
		begin
			pullup_dp <= pullup_en && line_now[0] && speed_full;
			pullup_dn <= pullup_en && line_now[0] && !speed_full;
			phy_on <= phy_en;
		end
	end

	// Forced line states; the pins are released in normal mode.
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			dp_o <= 1'b0;
			dn_o <= 1'b0;
			dp_oe <= 1'b0;
			dn_oe <= 1'b0;
		end
		else
		begin
			dp_oe <= test_mode != UEPD_TEST_NORMAL;
			dn_oe <= test_mode != UEPD_TEST_NORMAL;
			dp_o <= test_mode == UEPD_TEST_DIFF1;
			dn_o <= test_mode == UEPD_TEST_DIFF0;
		end
	end

	// Mode and configuration registers.
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			sof_deferred_send <= 1'b0;
			in_iso <= 1'b0;
			in_dbl <= 1'b0;
			out_iso <= 1'b0;
			out_dbl <= 1'b0;
			send_stall <= 1'b0;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				POWER_IDX: sof_deferred_send <= reg_wdata[PW_SOF_DEFER];
				IN_CSR_HI_IDX:
				begin
					in_iso <= reg_wdata[IN_ISO];
					in_dbl <= reg_wdata[IN_DBL];
				end
				OUT_CSR_HI_IDX:
				begin
					out_iso <= reg_wdata[OUT_ISO];
					out_dbl <= reg_wdata[OUT_DBL];
				end
				OUT_CSR_LO_IDX: send_stall <= reg_wdata[OUT_SEND_STALL];
				default:
				begin
					// Other indices hold no configuration.
				end
			endcase
		end
	end

	// Next IN slot counts: loads add a slot, sends remove one.
	always_comb
	begin
		next_in_slots = in_slots;
		next_in_rel = in_rel;
		if (in_send)
		begin
			next_in_slots = next_in_slots - 2'd1;
			next_in_rel = next_in_rel - 2'd1;
		end
		if (sof_tok)
		begin
			next_in_rel = next_in_slots;
		end
		if (fw_load_in)
		begin
			next_in_slots = next_in_slots + 2'd1;
			// Deferred iso packets stay held until the next frame start.
			if (!(in_iso && sof_deferred_send))
			begin
				next_in_rel = next_in_rel + 2'd1;
			end
		end
	end

	// IN slot state and the underrun flag; a new underrun beats a clear.
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			in_slots <= 2'd0;
			in_rel <= 2'd0;
			in_underrun_flag <= 1'b0;
		end
		else
		begin
			in_slots <= next_in_slots;
			in_rel <= next_in_rel;
			if (in_tok && in_iso && in_rel == 2'd0)
			begin
				in_underrun_flag <= 1'b1;
			end
			else if (wr_in_lo && !reg_wdata[IN_UNDERRUN])
			begin
				in_underrun_flag <= 1'b0;
			end
		end
	end

	// IN answers to the packet engine, one-cycle pulses.
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			tx_data_pkt <= 1'b0;
			tx_zlp <= 1'b0;
			in_event <= 1'b0;
		end
		else
		begin
			tx_data_pkt <= in_send;
			tx_zlp <= in_tok && !in_send && in_iso;
			in_event <= in_send;
		end
	end

	// OUT token handling: stall, refuse or open a reception.
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			rx_active <= 1'b0;
			rx_cnt <= '0;
			tx_stall <= 1'b0;
			tx_nak <= 1'b0;
			tx_ack <= 1'b0;
		end
		else
		begin
			tx_stall <= 1'b0;
			tx_nak <= in_tok && !in_send && !in_iso;
			tx_ack <= commit && !out_iso;
			if (commit)
			begin
				rx_active <= 1'b0;
			end
			else if (rx_active && fq.in_valid && fq.in_ready)
			begin
				rx_cnt <= rx_cnt + 1'b1;
			end
			if (out_tok && !rx_active)
			begin
				rx_cnt <= '0;
				if (send_stall && !out_iso)
				begin
					tx_stall <= 1'b1;
				end
				else if (out_pkts == out_cap)
				begin
					tx_nak <= !out_iso;
				end
				else
				begin
					rx_active <= 1'b1;
				end
			end
		end
	end

	// Packet lengths and the count of stored packets.
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			out_pkts <= 2'd0;
			len_wr_sel <= 1'b0;
			len_rd_sel <= 1'b0;
			len_mem[0] <= '0;
			len_mem[1] <= '0;
		end
		else
		begin
			if (commit)
			begin
				len_mem[len_wr_sel] <= rx_cnt;
				len_wr_sel <= !len_wr_sel;
			end
			if (fw_clear_out)
			begin
				len_rd_sel <= !len_rd_sel;
			end
			out_pkts <= out_pkts + {1'b0, commit} - {1'b0, fw_clear_out};
		end
	end

	// OUT ready flag: set when a packet is held and the flag is clear.
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			out_packet_ready <= 1'b0;
		end
		else if (fw_clear_out)
		begin
			out_packet_ready <= 1'b0;
		end
		else if (out_pkts != 2'd0)
		begin
			out_packet_ready <= 1'b1;
		end
	end

	// OUT event pulse: ready newly set, stall sent or overrun.
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			out_event <= 1'b0;
		end
		else
		begin
			out_event <= (!out_packet_ready && out_pkts != 2'd0 && !fw_clear_out)
				|| tx_stall
				|| (out_tok && !rx_active && out_iso && out_pkts == out_cap);
		end
	end

	// Sticky OUT flags; a hardware set in the clearing cycle wins.
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			stall_sent_flag <= 1'b0;
			out_overrun_flag <= 1'b0;
			data_error_flag <= 1'b0;
		end
		else
		begin
			if (tx_stall)
			begin
				stall_sent_flag <= 1'b1;
			end
			else if (wr_out_lo && !reg_wdata[OUT_STALL_SENT])
			begin
				stall_sent_flag <= 1'b0;
			end
			if (out_tok && !rx_active && out_iso && out_pkts == out_cap)
			begin
				out_overrun_flag <= 1'b1;
			end
			else if (wr_out_lo && !reg_wdata[OUT_OVERRUN])
			begin
				out_overrun_flag <= 1'b0;
			end
			if (commit && out_iso && rx_crc_err)
			begin
				data_error_flag <= 1'b1;
			end
			else if (wr_out_lo && !reg_wdata[OUT_DATA_ERR])
			begin
				data_error_flag <= 1'b0;
			end
		end
	end

	// Registered read data; reads of unused indices return zero.
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			reg_rdata <= 8'h00;
		end
		else if (reg_rd)
		begin
			case (reg_addr)
				XCVR_CTRL_IDX: reg_rdata <= {pullup_en, phy_en, speed_full, test_mode,
					line_now[1] && !line_now[2], line_now[1], line_now[2]};
				POWER_IDX: reg_rdata <= {sof_deferred_send, 7'h00};
				IN_CSR_LO_IDX: reg_rdata <= {5'h00, in_underrun_flag, 1'b0, in_packet_ready};
				IN_CSR_HI_IDX: reg_rdata <= {in_dbl, in_iso, 6'h00};
				OUT_CSR_LO_IDX: reg_rdata <= {1'b0, stall_sent_flag, send_stall, 1'b0,
					data_error_flag, out_overrun_flag, 1'b0, out_packet_ready};
				OUT_CSR_HI_IDX: reg_rdata <= {out_dbl, out_iso, 6'h00};
				OUT_CNT_LO_IDX: reg_rdata <= out_count[7:0];
				OUT_CNT_HI_IDX: reg_rdata <= {6'h00, out_count[CNT_W-1:8]};
				FIFO_IDX: reg_rdata <= fq.out_valid ? fq.out_data : 8'h00;
				default: reg_rdata <= 8'h00;
			endcase
		end
	end
endmodule
`default_nettype wire

//--- design/uepd_pkg.sv
// Shared constants for the endpoint data and transceiver control block.
package uepd_pkg;
	// Register indices on the byte-wide register port.
	localparam logic [3:0] XCVR_CTRL_IDX = 4'h0;
	localparam logic [3:0] POWER_IDX = 4'h1;
	localparam logic [3:0] IN_CSR_LO_IDX = 4'h2;
	localparam logic [3:0] IN_CSR_HI_IDX = 4'h3;
	localparam logic [3:0] OUT_CSR_LO_IDX = 4'h4;
	localparam logic [3:0] OUT_CSR_HI_IDX = 4'h5;
	localparam logic [3:0] OUT_CNT_LO_IDX = 4'h6;
	localparam logic [3:0] OUT_CNT_HI_IDX = 4'h7;
	localparam logic [3:0] FIFO_IDX = 4'h8;
	// Transceiver control field positions.
	localparam int XC_PULLUP = 7;
	localparam int XC_PHY_EN = 6;
	localparam int XC_SPEED = 5;
	localparam int XC_TEST_HI = 4;
	localparam int XC_TEST_LO = 3;
	localparam int XC_DIFF = 2;
	localparam int XC_DP = 1;
	localparam int XC_DN = 0;
	localparam logic [4:0] XC_RESET = 5'h00;
	// Power register: start-of-frame deferred send bit.
	localparam int PW_SOF_DEFER = 7;
	// IN control/status field positions.
	localparam int IN_RDY = 0;
	localparam int IN_UNDERRUN = 2;
	localparam int IN_ISO = 6;
	localparam int IN_DBL = 7;
	// OUT control/status field positions.
	localparam int OUT_RDY = 0;
	localparam int OUT_OVERRUN = 2;
	localparam int OUT_DATA_ERR = 3;
	localparam int OUT_SEND_STALL = 5;
	localparam int OUT_STALL_SENT = 6;
	localparam int OUT_ISO = 6;
	localparam int OUT_DBL = 7;
	// Line test modes.
	typedef enum logic [1:0] {
		UEPD_TEST_NORMAL,
		UEPD_TEST_DIFF1,
		UEPD_TEST_DIFF0,
		UEPD_TEST_SE0
	} uepd_test_t;
	// Default depth and width of the OUT data FIFO.
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_WIDTH = 8;
	// Width of the OUT byte counter.
	localparam int CNT_W = 10;
endpackage

//--- design/uepd_fifo_if.sv
// Valid/ready carrier between the endpoint logic and its OUT data FIFO.
`timescale 1ns/10ps
`default_nettype none
interface uepd_fifo_if #(parameter int WIDTH = 8);
	// Filling side.
	logic in_valid;
	logic in_ready;
	logic [WIDTH-1:0] in_data;
	// Draining side.
	logic out_valid;
	logic out_ready;
	logic [WIDTH-1:0] out_data;
	// The FIFO receives on the filling side and answers on the draining side.
	modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
	// The endpoint logic drives data in and pulls data out.
	modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface
`default_nettype wire

//--- design/uepd_fifo.sv
// Synchronous FIFO with registered full and empty flags.
`timescale 1ns/10ps
`default_nettype none
module uepd_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic ref_clk,
	input wire logic srst,
	uepd_fifo_if.fifo port
);
	localparam int AW = $clog2(DEPTH);
	// Storage array.
	logic [WIDTH-1:0] mem [DEPTH];
	// Read and write pointers.
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	// Fill level, one wider than the pointers.
	logic [AW:0] level;
	// Push and pop qualifiers.
	logic push;
	logic pop;

	assign push = port.in_valid && port.in_ready;
	assign pop = port.out_valid && port.out_ready;
	assign port.out_data = mem[rd_ptr];

	// Storage write.
	always_ff @(posedge ref_clk)
	begin
		if (push)
		begin
			mem[wr_ptr] <= port.in_data;
		end
	end

	// Pointer and level tracking; flags are flops so they never glitch.
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level <= '0;
			port.in_ready <= 1'b1;
			port.out_valid <= 1'b0;
		end
		else
		begin
			if (push)
			begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop)
			begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			if (push && !pop)
			begin
				level <= level + 1'b1;
				port.in_ready <= (level + 1'b1) != (AW + 1)'(DEPTH);
				port.out_valid <= 1'b1;
			end
			else if (pop && !push)
			begin
				level <= level - 1'b1;
				port.in_ready <= 1'b1;
				port.out_valid <= level != (AW + 1)'(1);
			end
		end
	end
endmodule
`default_nettype wire

//--- sim/uepd_top_asserts.sv
// Concurrent checks on the pins of the endpoint and transceiver block.
`timescale 1ns/10ps
`default_nettype none
module uepd_top_asserts (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic in_tok,
	input wire logic out_tok,
	input wire logic rx_end,
	input wire logic vbus,
	input wire logic tx_data_pkt,
	input wire logic tx_zlp,
	input wire logic tx_nak,
	input wire logic tx_ack,
	input wire logic tx_stall,
	input wire logic in_event,
	input wire logic out_event,
	input wire logic dp_oe,
	input wire logic dn_oe,
	input wire logic pullup_dp,
	input wire logic pullup_dn
);
	// All checks use the one clock and are quiet during reset.
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (srst);
	a_in_answer: assert property (in_tok |=> (tx_data_pkt || tx_zlp || tx_nak))
		else $error("IN token got no answer");
	a_one_answer: assert property ($onehot0({tx_data_pkt, tx_zlp, tx_nak}))
		else $error("Two IN answers at once");
	a_answer_cause: assert property ((tx_data_pkt || tx_zlp) |-> $past(in_tok))
		else $error("IN answer without a token");
	a_event_sent: assert property (in_event |-> tx_data_pkt)
		else $error("IN event without a sent packet");
	a_stall_cause: assert property (tx_stall |-> $past(out_tok))
		else $error("Stall without an OUT token");
	a_stall_event: assert property (tx_stall |-> ##[0:2] out_event)
		else $error("Stall raised no OUT event");
	a_ack_commit: assert property (tx_ack |-> $past(rx_end))
		else $error("ACK not after packet end");
	a_pullup_vbus: assert property (!vbus [*8] |-> !(pullup_dp || pullup_dn))
		else $error("Pull-up on without bus power");
	a_pullup_side: assert property (!(pullup_dp && pullup_dn))
		else $error("Pull-up on both lines");
	a_test_pair: assert property (dp_oe == dn_oe)
		else $error("Test drive enables differ");
	a_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
		else $error("Read data moved without a read");
	// Main scenarios that the bench must reach.
	c_zlp: cover property (tx_zlp);
	c_stall: cover property (tx_stall);
	c_ack: cover property (tx_ack);
endmodule
`default_nettype wire

//--- sim/uepd_host_model.sv
// Behavioural host controller issuing tokens and OUT data packets.
`timescale 1ns/10ps
`default_nettype none
module uepd_host_model (
	input wire logic ref_clk,
	input wire logic rx_ready,
	output logic sof_tok,
	output logic in_tok,
	output logic out_tok,
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_end,
	output logic rx_crc_err
);
	int stalls;
	// Idle bus at time zero.
	initial
	begin
		{sof_tok, in_tok, out_tok, rx_valid, rx_end, rx_crc_err} = 6'h00;
		rx_data = 8'h5a;
		stalls = 0;
	end
	// One-cycle token: 0 frame start, 1 IN, 2 OUT.
	task tok(input int k);
		@(negedge ref_clk);
		sof_tok = (k == 0);
		in_tok = (k == 1);
		out_tok = (k == 2);
		@(negedge ref_clk);
		{sof_tok, in_tok, out_tok} = 3'h0;
	endtask
	// OUT token then bytes, each held until the endpoint is ready for it or 20 cycles have passed.
	task out_pkt(input logic [7:0] d[$], input logic crc);
		int w;
		tok(2);
		foreach (d[i])
		begin
			rx_valid = 1'b1;
			rx_data = d[i];
			w = 0;
			while (rx_ready !== 1'b1 && w < 20)
			begin
				w++;
				@(negedge ref_clk);
			end
			if (w == 20)
				stalls++;
			@(negedge ref_clk);
		end
		// A released data line must not keep its last value.
		rx_valid = 1'b0;
		rx_data = ~rx_data;
		rx_end = 1'b1;
		rx_crc_err = crc;
		@(negedge ref_clk);
		rx_end = 1'b0;
		rx_crc_err = 1'b0;
	endtask
endmodule
`default_nettype wire

//--- sim/uepd_top_tb.sv
// Self-checking bench for the endpoint data and transceiver block.
`timescale 1ns/10ps
`default_nettype none
module uepd_top_tb;
	import uepd_pkg::*;
	logic ref_clk, srst, reg_wr, reg_rd, vbus, dp_h, dn_h;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, rx_data, rd, x;
	logic sof_tok, in_tok, out_tok, rx_valid, rx_end, rx_crc_err, rx_ready;
	logic tx_data_pkt, tx_zlp, tx_nak, tx_ack, tx_stall, in_event, out_event;
	logic dp_o, dn_o, dp_oe, dn_oe, pullup_dp, pullup_dn, phy_on;
	logic [1:0] l;
	logic [6:0] pv;
	int n_errors, num_checks, seed, n, cnt[7], base[7];
	logic [7:0] q[$], d[$];
	// Wire level: forced drive wins over the host's idle levels.
	wire logic dp_i = (dp_oe === 1'b1) ? dp_o : dp_h;
	wire logic dn_i = (dn_oe === 1'b1) ? dn_o : dn_h;
	uepd_top #(.DEPTH(16)) u_uepd_top (.*);
	uepd_host_model u_uepd_host_model (.*);
	assign pv = {out_event, in_event, tx_stall, tx_ack, tx_nak, tx_zlp, tx_data_pkt};
	// Clock of 100 ns.
	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	// Tally every one-cycle pulse output.
	always @(posedge ref_clk)
	begin
		foreach (cnt[i])
			if (pv[i] === 1'b1)
				cnt[i]++;
	end
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] v);
		@(negedge ref_clk);
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(negedge ref_clk);
		reg_wr = 1'b0;
	endtask
	task rdr(input logic [3:0] a);
		@(negedge ref_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge ref_clk);
		reg_rd = 1'b0;
		rd = reg_rdata;
	endtask
	// Pulse counts are compared as growth since the last mark.
	task mark;
		repeat (3) @(negedge ref_clk);
		base = cnt;
	endtask
	task dlt(input int i, input int e);
		repeat (3) @(negedge ref_clk);
		chk("pulse count", 8'(e), 8'(cnt[i] - base[i]));
	endtask
	// Random OUT packet whose bytes are remembered for unloading.
	task pkt(input int k, input logic crc);
		d.delete();
		repeat (k) d.push_back(8'($random(seed)));
		q = {q, d};
		u_uepd_host_model.out_pkt(d, crc);
	endtask
	// Firmware unload: count, bytes, then clear ready.
	task unload(input int k);
		rdr(OUT_CNT_LO_IDX);
		chk("count lo", 8'(k), rd);
		rdr(OUT_CNT_HI_IDX);
		chk("count hi", 8'h00, rd);
		repeat (k)
		begin
			rdr(FIFO_IDX);
			chk("fifo byte", q.pop_front(), rd);
		end
		wr(OUT_CSR_LO_IDX, 8'h00);
	endtask
	function automatic logic [1:0] lines(logic [1:0] m, logic [1:0] h);
		case (m)
			2'h1: return 2'h2;
			2'h2: return 2'h1;
			2'h3: return 2'h0;
			default: return h;
		endcase
	endfunction
	task test_done;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Cuts a hang short.
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		n_errors++;
		$display("ERROR watchdog expected 0 seen 1");
		test_done;
	end
	initial
	begin
		seed = 32'ha17a;
		{srst, reg_wr, reg_rd, vbus, dp_h, dn_h} = 6'h20;
		{reg_addr, reg_wdata} = 12'h000;
		repeat (6) @(negedge ref_clk);
		srst = 1'b0;
		rdr(XCVR_CTRL_IDX);
		chk("xcvr reset", 8'h00, rd);
		chk("phy reset", 8'h00, {7'h0, phy_on});
		rdr(4'hf);
		chk("unmapped", 8'h00, rd);
		for (int m = 0; m < 8; m++)
		begin
			x = {1'($random(seed)), 1'b1, 1'($random(seed)), 2'(m), 3'h0};
			{dp_h, dn_h} = 2'($random(seed));
			// Bus power comes and goes at random so the pull-up gate is exercised.
			vbus = 1'($random(seed));
			wr(XCVR_CTRL_IDX, x);
			repeat (8) @(negedge ref_clk);
			chk("pullup", {6'h0, x[7] & vbus & x[5], x[7] & vbus & ~x[5]}, {6'h0, pullup_dp, pullup_dn});
			chk("phy on", 8'h01, {7'h0, phy_on});
			chk("oe", {6'h0, {2{x[4:3] != 2'h0}}}, {6'h0, dp_oe, dn_oe});
			l = lines(x[4:3], {dp_h, dn_h});
			rdr(XCVR_CTRL_IDX);
			chk("status", {x[7:3], l[1] & ~l[0], l}, rd);
		end
		wr(XCVR_CTRL_IDX, 8'ha0);
		vbus = 1'b0;
		repeat (10) @(negedge ref_clk);
		chk("pullup off", 8'h00, {5'h0, pullup_dp, pullup_dn, phy_on});
		n = 1 + ($random(seed) & 7);
		mark;
		pkt(n, 1'b0);
		dlt(3, 1);
		chk("out event", 8'h01, 8'(cnt[6] - base[6]));
		rdr(OUT_CSR_LO_IDX);
		chk("out ready", 8'h01, rd);
		unload(n);
		wr(OUT_CSR_HI_IDX, 8'h80);
		pkt(3, 1'b0);
		pkt(4, 1'b0);
		// Both buffers are held, so a further bulk OUT token is refused with a NAK.
		mark;
		u_uepd_host_model.tok(2);
		dlt(2, 1);
		unload(3);
		rdr(OUT_CSR_LO_IDX);
		chk("ready again", 8'h01, rd);
		dlt(6, 1);
		unload(4);
		dlt(6, 1);
		wr(OUT_CSR_HI_IDX, 8'h00);
		wr(OUT_CSR_LO_IDX, 8'h20);
		mark;
		d = {8'h11, 8'h22};
		u_uepd_host_model.out_pkt(d, 1'b0);
		dlt(4, 1);
		chk("stall event", 8'h01, 8'(cnt[6] - base[6]));
		chk("no ack", 8'h00, 8'(cnt[3] - base[3]));
		rdr(OUT_CSR_LO_IDX);
		chk("stall flag", 8'h60, rd);
		wr(OUT_CSR_LO_IDX, 8'h00);
		rdr(OUT_CSR_LO_IDX);
		chk("stall clear", 8'h00, rd);
		wr(OUT_CSR_HI_IDX, 8'h40);
		mark;
		pkt(5, 1'b1);
		dlt(6, 1);
		rdr(OUT_CSR_LO_IDX);
		chk("iso crc", 8'h09, rd);
		mark;
		u_uepd_host_model.out_pkt(d, 1'b0);
		dlt(6, 1);
		rdr(OUT_CSR_LO_IDX);
		chk("overrun", 8'h0d, rd);
		unload(5);
		wr(IN_CSR_HI_IDX, 8'hc0);
		mark;
		u_uepd_host_model.tok(1);
		dlt(1, 1);
		rdr(IN_CSR_LO_IDX);
		chk("underrun", 8'h04, rd);
		wr(IN_CSR_LO_IDX, 8'h01);
		rdr(IN_CSR_LO_IDX);
		chk("slot free", 8'h00, rd);
		wr(IN_CSR_LO_IDX, 8'h01);
		rdr(IN_CSR_LO_IDX);
		chk("slots full", 8'h01, rd);
		mark;
		repeat (3) u_uepd_host_model.tok(1);
		dlt(0, 2);
		chk("in events", 8'h02, 8'(cnt[5] - base[5]));
		chk("late zlp", 8'h01, 8'(cnt[1] - base[1]));
		wr(POWER_IDX, 8'h80);
		wr(IN_CSR_LO_IDX, 8'h01);
		mark;
		u_uepd_host_model.tok(1);
		dlt(1, 1);
		mark;
		u_uepd_host_model.tok(0);
		u_uepd_host_model.tok(1);
		dlt(0, 1);
		chk("host stalls", 8'h00, 8'(u_uepd_host_model.stalls));
		test_done;
	end
endmodule
bind uepd_top uepd_top_asserts u_chk (.*);
`default_nettype wire
